// [rtl/bst_params.svh]
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// Instruction register
`define BST_IR_W        4
`define BST_IR_EXTEST   4'h0
`define BST_IR_SAMPLE   4'h1
`define BST_IR_IDCODE   4'h2
`define BST_IR_INTEST   4'h3
`define BST_IR_PARSCAN  4'h8
`define BST_IR_BYPASS   4'hf
// Low two bits fixed at 01 on capture, upper bits zero
`define BST_IR_CAPTURE  4'h1

// Identification register; value is arbitrary, not a real maker code
`define BST_ID_W        32
`define BST_ID_CODE     32'h1000_0001

// Default pin and parity generator counts
`define BST_N_IN        8
`define BST_N_OUT       8
`define BST_N_PAR       4

`endif

// [rtl/bst_pkg.sv]
package bst_pkg;

  typedef enum logic [3:0] {
    BST_TLR  = 4'hf, BST_RTI  = 4'hc, BST_SDS  = 4'h7, BST_CDR  = 4'h6,
    BST_SHDR = 4'h2, BST_E1DR = 4'h1, BST_PDR  = 4'h3, BST_E2DR = 4'h0,
    BST_UDR  = 4'h5, BST_SIS  = 4'h4, BST_CIR  = 4'he, BST_SHIR = 4'ha,
    BST_E1IR = 4'h9, BST_PIR  = 4'hb, BST_E2IR = 4'h8, BST_UIR  = 4'hd
  } bst_state_t;

  typedef enum logic [1:0] {
    BST_DR_BYP = 2'b00,
    BST_DR_ID  = 2'b01,
    BST_DR_BSR = 2'b10,
    BST_DR_PAR = 2'b11
  } bst_dr_t;

  // Mode levels that cross into the system clock domain
  typedef struct packed {
    logic extest;
    logic intest;
    logic partest;
  } bst_ctl_t;

  typedef struct packed {
    bst_ctl_t ctl;
    bst_dr_t  dr;
  } bst_mode_t;

endpackage : bst_pkg

// [rtl/bst_tap.sv]
// How it works
// - Test logic only moves on test clock edges or test reset, so a stopped clock freezes it.
// - Mode select and serial data in are sampled on rising test clock edges.
// - Test reset low forces the controller to reset state without a clock edge.
// - A sixteen-state controller steps on each rising edge as mode select directs.
// - Decoder supports sample/preload, intest, extest and bypass, each picking a register.
// - Instruction register shifts and loads a fixed pattern in capture state.
// - Private parity instruction puts the parity chain between data in and out.
// - Bypass is one shift stage between data in and data out.
// - Extest puts the boundary register in the scan path for board tests.
// - Under extest all functional outputs can be disabled from the scan chain.
// - Intest drives the core from shifted patterns and captures its responses.
// - Sample captures pin signals while the core keeps running normally.
// - Preload fills the update stages without changing system behaviour.
// - Identification register is selected by the identification instruction.
// - Parity chain forces parity generator nodes so stored data carries bad parity.
// - Parity chain holds exactly one bit per parity generator.
// - Every functional pin has a boundary shift stage beside it.
// - Cells either capture their signal-in or drive their stored value out.
// - A separately clocked update stage holds outputs steady while shifting.
`timescale 1ns/10ps
`include "bst_params.svh"

module bst_tap #(
  parameter int          N_IN    = `BST_N_IN,
  parameter int          N_OUT   = `BST_N_OUT,
  parameter int          N_PAR   = `BST_N_PAR,
  parameter int          IR_W    = `BST_IR_W,
  // Arbitrary value, not any real maker code
  parameter logic [31:0] ID_CODE = `BST_ID_CODE
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             test_clock_in_i,
  input  wire logic             test_reset_n_i,
  input  wire logic             test_mode_sel_i,
  input  wire logic             test_data_i,
  output logic                  test_data_o,
  output logic                  test_data_oe_o,
  input  wire logic [N_IN-1:0]  pin_in_i,
  output logic      [N_IN-1:0]  core_in_o,
  input  wire logic [N_OUT-1:0] core_out_i,
  input  wire logic             core_oe_i,
  output logic      [N_OUT-1:0] pad_out_o,
  output logic                  pad_oe_o,
  output logic      [N_PAR-1:0] parity_force_o
);

  localparam int BSR_LEN = N_IN + N_OUT + 1;
  localparam int OUT_LO  = N_IN;
  localparam int CTL_BIT = N_IN + N_OUT;

  function automatic bst_pkg::bst_mode_t decode(input logic [IR_W-1:0] ir);
    bst_pkg::bst_mode_t m;
    m = '0;
    case (ir)
      `BST_IR_EXTEST: begin
        m.ctl.extest = 1'b1;
        m.dr = bst_pkg::BST_DR_BSR;
      end
      `BST_IR_INTEST: begin
        m.ctl.intest = 1'b1;
        m.dr = bst_pkg::BST_DR_BSR;
      end
      `BST_IR_SAMPLE:  m.dr = bst_pkg::BST_DR_BSR;
      `BST_IR_IDCODE:  m.dr = bst_pkg::BST_DR_ID;
      `BST_IR_PARSCAN: begin
        m.ctl.partest = 1'b1;
        m.dr = bst_pkg::BST_DR_PAR;
      end
      // Unknown codes fall back to bypass
      default: m.dr = bst_pkg::BST_DR_BYP;
    endcase
    return m;
  endfunction : decode

  bst_pkg::bst_state_t state_r;
  bst_pkg::bst_state_t state_nxt;
  bst_pkg::bst_mode_t  mode_r;
  logic [IR_W-1:0]     ir_sh_r;
  logic [IR_W-1:0]     ir_r;
  logic                bypass_r;
  logic [31:0]         id_sh_r;
  logic [BSR_LEN-1:0]  bsr_sh_r;
  logic [BSR_LEN-1:0]  bsr_upd_r;
  logic [N_PAR-1:0]    par_sh_r;
  logic [N_PAR-1:0]    par_upd_r;
  logic                upd_tgl_r;
  logic [BSR_LEN-1:0]  cap_meta_r;
  logic [BSR_LEN-1:0]  cap_sync_r;
  logic                tdo_r;
  logic                tdo_oe_r;
  logic                tdo_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bst_pkg::BST_TLR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_TLR  : bst_pkg::BST_RTI;
      bst_pkg::BST_RTI:  state_nxt = test_mode_sel_i ? bst_pkg::BST_SDS  : bst_pkg::BST_RTI;
      bst_pkg::BST_SDS:  state_nxt = test_mode_sel_i ? bst_pkg::BST_SIS  : bst_pkg::BST_CDR;
      bst_pkg::BST_CDR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_E1DR : bst_pkg::BST_SHDR;
      bst_pkg::BST_SHDR: state_nxt = test_mode_sel_i ? bst_pkg::BST_E1DR : bst_pkg::BST_SHDR;
      bst_pkg::BST_E1DR: state_nxt = test_mode_sel_i ? bst_pkg::BST_UDR  : bst_pkg::BST_PDR;
      bst_pkg::BST_PDR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_E2DR : bst_pkg::BST_PDR;
      bst_pkg::BST_E2DR: state_nxt = test_mode_sel_i ? bst_pkg::BST_UDR  : bst_pkg::BST_SHDR;
      bst_pkg::BST_UDR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_SDS  : bst_pkg::BST_RTI;
      bst_pkg::BST_SIS:  state_nxt = test_mode_sel_i ? bst_pkg::BST_TLR  : bst_pkg::BST_CIR;
      bst_pkg::BST_CIR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_E1IR : bst_pkg::BST_SHIR;
      bst_pkg::BST_SHIR: state_nxt = test_mode_sel_i ? bst_pkg::BST_E1IR : bst_pkg::BST_SHIR;
      bst_pkg::BST_E1IR: state_nxt = test_mode_sel_i ? bst_pkg::BST_UIR  : bst_pkg::BST_PIR;
      bst_pkg::BST_PIR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_E2IR : bst_pkg::BST_PIR;
      bst_pkg::BST_E2IR: state_nxt = test_mode_sel_i ? bst_pkg::BST_UIR  : bst_pkg::BST_SHIR;
      bst_pkg::BST_UIR:  state_nxt = test_mode_sel_i ? bst_pkg::BST_SDS  : bst_pkg::BST_RTI;
    endcase
  end

  // Only clock edges and test reset move state, so a stopped test clock holds everything
  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      state_r <= bst_pkg::BST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pins and core outputs are foreign to the test clock
  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      cap_meta_r <= '0;
      cap_sync_r <= '0;
    end else begin
      cap_meta_r <= {core_oe_i, core_out_i, pin_in_i};
      cap_sync_r <= cap_meta_r;
    end
  end

  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      ir_sh_r <= '0;
    end else if (state_r == bst_pkg::BST_CIR) begin
      ir_sh_r <= `BST_IR_CAPTURE;
    end else if (state_r == bst_pkg::BST_SHIR) begin
      ir_sh_r <= {test_data_i, ir_sh_r[IR_W-1:1]};
    end
  end

  // Instruction takes effect on the falling edge in update state
  always_ff @(negedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      ir_r   <= `BST_IR_IDCODE;
      mode_r <= decode(`BST_IR_IDCODE);
    end else if (state_r == bst_pkg::BST_TLR) begin
      ir_r   <= `BST_IR_IDCODE;
      mode_r <= decode(`BST_IR_IDCODE);
    end else if (state_r == bst_pkg::BST_UIR) begin
      ir_r   <= ir_sh_r;
      mode_r <= decode(ir_sh_r);
    end
  end

  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      bypass_r <= 1'b0;
    end else if (state_r == bst_pkg::BST_CDR) begin
      bypass_r <= 1'b0;
    end else if (state_r == bst_pkg::BST_SHDR && mode_r.dr == bst_pkg::BST_DR_BYP) begin
      bypass_r <= test_data_i;
    end
  end

  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      id_sh_r <= '0;
    end else if (mode_r.dr == bst_pkg::BST_DR_ID) begin
      if (state_r == bst_pkg::BST_CDR) begin
        id_sh_r <= ID_CODE;
      end else if (state_r == bst_pkg::BST_SHDR) begin
        id_sh_r <= {test_data_i, id_sh_r[31:1]};
      end
    end
  end

  // Input cells see pins, output cells see core outputs and enable
  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      bsr_sh_r <= '0;
    end else if (mode_r.dr == bst_pkg::BST_DR_BSR) begin
      if (state_r == bst_pkg::BST_CDR) begin
        bsr_sh_r <= cap_sync_r;
      end else if (state_r == bst_pkg::BST_SHDR) begin
        bsr_sh_r <= {test_data_i, bsr_sh_r[BSR_LEN-1:1]};
      end
    end
  end

  always_ff @(posedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      par_sh_r <= '0;
    end else if (mode_r.dr == bst_pkg::BST_DR_PAR) begin
      if (state_r == bst_pkg::BST_CDR) begin
        par_sh_r <= par_upd_r;
      end else if (state_r == bst_pkg::BST_SHDR) begin
        par_sh_r <= {test_data_i, par_sh_r[N_PAR-1:1]};
      end
    end
  end

  // Update stages clock on the opposite edge, so shifting never disturbs them
  always_ff @(negedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      bsr_upd_r <= '0;
      par_upd_r <= '0;
      upd_tgl_r <= 1'b0;
    end else if (state_r == bst_pkg::BST_UDR) begin
      if (mode_r.dr == bst_pkg::BST_DR_BSR) begin
        bsr_upd_r <= bsr_sh_r;
        upd_tgl_r <= ~upd_tgl_r;
      end else if (mode_r.dr == bst_pkg::BST_DR_PAR) begin
        par_upd_r <= par_sh_r;
        upd_tgl_r <= ~upd_tgl_r;
      end
    end
  end

  always_comb begin
    tdo_nxt = bypass_r;
    if (state_r == bst_pkg::BST_SHIR) begin
      tdo_nxt = ir_sh_r[0];
    end else begin
      unique case (mode_r.dr)
        bst_pkg::BST_DR_BYP: tdo_nxt = bypass_r;
        bst_pkg::BST_DR_ID:  tdo_nxt = id_sh_r[0];
        bst_pkg::BST_DR_BSR: tdo_nxt = bsr_sh_r[0];
        bst_pkg::BST_DR_PAR: tdo_nxt = par_sh_r[0];
      endcase
    end
  end

  always_ff @(negedge test_clock_in_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= (state_r == bst_pkg::BST_SHIR) || (state_r == bst_pkg::BST_SHDR);
    end
  end

  assign test_data_o    = tdo_r;
  assign test_data_oe_o = tdo_oe_r;

  // Mode bits are used only once two samples agree, so skew never mixes modes
  bst_pkg::bst_ctl_t   ctl_meta_r;
  bst_pkg::bst_ctl_t   ctl_sync_r;
  bst_pkg::bst_ctl_t   ctl_prev_r;
  bst_pkg::bst_ctl_t   ctl_use_r;
  logic                tgl_meta_r;
  logic                tgl_sync_r;
  logic                tgl_seen_r;
  logic [BSR_LEN-1:0]  bsr_hold_r;
  logic [N_PAR-1:0]    par_hold_r;
  logic [N_IN-1:0]     pin_meta_r;
  logic [N_IN-1:0]     pin_sync_r;
  logic [N_IN-1:0]     core_in_r;
  logic [N_OUT-1:0]    pad_out_r;
  logic                pad_oe_r;
  logic [N_PAR-1:0]    par_force_r;
  logic                drive_pins;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_meta_r <= '0;
      ctl_sync_r <= '0;
      ctl_prev_r <= '0;
      ctl_use_r  <= '0;
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      ctl_meta_r <= mode_r.ctl;
      ctl_sync_r <= ctl_meta_r;
      ctl_prev_r <= ctl_sync_r;
      ctl_use_r  <= (ctl_sync_r == ctl_prev_r) ? ctl_sync_r : ctl_use_r;
      tgl_meta_r <= upd_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Update words are frozen for several test clocks after the toggle,
  // so sampling them on the synchronised toggle edge is safe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bsr_hold_r <= '0;
      par_hold_r <= '0;
    end else if (tgl_sync_r != tgl_seen_r) begin
      bsr_hold_r <= bsr_upd_r;
      par_hold_r <= par_upd_r;
    end
  end

  assign drive_pins = ctl_use_r.extest || ctl_use_r.intest;

  // Sample and preload leave the functional path untouched
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      core_in_r   <= '0;
      pad_out_r   <= '0;
      pad_oe_r    <= 1'b0;
      par_force_r <= '0;
    end else begin
      core_in_r   <= ctl_use_r.intest ? bsr_hold_r[N_IN-1:0] : pin_sync_r;
      pad_out_r   <= drive_pins ? bsr_hold_r[CTL_BIT-1:OUT_LO] : core_out_i;
      pad_oe_r    <= drive_pins ? bsr_hold_r[CTL_BIT] : core_oe_i;
      par_force_r <= ctl_use_r.partest ? par_hold_r : '0;
    end
  end

  assign core_in_o      = core_in_r;
  assign pad_out_o      = pad_out_r;
  assign pad_oe_o       = pad_oe_r;
  assign parity_force_o = par_force_r;

  a_tlr_by_ones: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    test_mode_sel_i [*5] |=> state_r == bst_pkg::BST_TLR)
    else $error("five high mode selects did not reach reset state");

  a_ir_capture: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    state_r == bst_pkg::BST_CIR |=> ir_sh_r == `BST_IR_CAPTURE)
    else $error("instruction capture pattern wrong");

  a_ir_shift_in: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    state_r == bst_pkg::BST_SHIR |=> ir_sh_r[IR_W-1] == $past(test_data_i))
    else $error("instruction shift lost serial input");

  a_bypass_one_stage: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    (state_r == bst_pkg::BST_SHDR && mode_r.dr == bst_pkg::BST_DR_BYP)
    |=> test_data_o == $past(test_data_i))
    else $error("bypass path is not one stage");

  a_id_capture: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    (state_r == bst_pkg::BST_CDR && mode_r.dr == bst_pkg::BST_DR_ID)
    |=> id_sh_r == ID_CODE)
    else $error("identification code not captured");

  a_tdo_enable: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    test_data_oe_o == (state_r == bst_pkg::BST_SHIR || state_r == bst_pkg::BST_SHDR))
    else $error("data out enabled outside shift");

  a_update_hold: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    $changed(bsr_upd_r) |-> state_r == bst_pkg::BST_UDR && mode_r.dr == bst_pkg::BST_DR_BSR)
    else $error("boundary update stage changed outside update");

  a_par_shift_in: assert property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    (state_r == bst_pkg::BST_SHDR && mode_r.dr == bst_pkg::BST_DR_PAR)
    |=> par_sh_r[N_PAR-1] == $past(test_data_i))
    else $error("parity chain did not take serial input");

  a_extest_enable: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ctl_use_r.extest |=> pad_oe_o == $past(bsr_hold_r[CTL_BIT]))
    else $error("output enable not from boundary cell under extest");

  a_parity_idle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !ctl_use_r.partest |=> parity_force_o == '0)
    else $error("parity forced outside parity instruction");

  c_extest_update: cover property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    state_r == bst_pkg::BST_UDR && mode_r.ctl.extest);

  c_id_shift: cover property (
    @(posedge test_clock_in_i) disable iff (!test_reset_n_i)
    state_r == bst_pkg::BST_SHDR && mode_r.dr == bst_pkg::BST_DR_ID);

  c_parity_forced: cover property (
    @(posedge clock_i) disable iff (rst_i)
    parity_force_o != '0);

endmodule : bst_tap

// [testbench/boundary_scan_test_port_tb.sv]
`timescale 1ns/10ps
`include "bst_params.svh"

module boundary_scan_test_port_tb;
  logic        clock_i;
  logic        rst_i;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        trst_n;
  logic        tdo;
  logic        tdo_oe;
  logic [7:0]  pin_in;
  logic [7:0]  core_in;
  logic [7:0]  core_out;
  logic        core_oe;
  logic [7:0]  pad_out;
  logic        pad_oe;
  logic [3:0]  par_force;
  logic [63:0] d;
  logic        ok;
  logic        sys_hold;
  int          err_count = 0;
  int          cmp_count = 0;

  bst_tap DUT (
    .clock_i(clock_i), .rst_i(rst_i), .test_clock_in_i(tck), .test_reset_n_i(trst_n),
    .test_mode_sel_i(tms), .test_data_i(tdi), .test_data_o(tdo), .test_data_oe_o(tdo_oe),
    .pin_in_i(pin_in), .core_in_o(core_in), .core_out_i(core_out), .core_oe_i(core_oe),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .parity_force_o(par_force)
  );

  bst_tester tester (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe)
  );

  // System clock parked high whenever the test clock may run
  always #5 clock_i = sys_hold ? 1'b1 : ~clock_i;

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Crossing into the system domain takes a few system clocks
  task settle;
    sys_hold = 1'b0;
    repeat (12) @(posedge clock_i);
    #1;
    sys_hold = 1'b1;
  endtask : settle

  task ir_load(input logic [3:0] code);
    tester.scan(1'b1, 4, {60'h0, code}, -1, d, ok);
    check("ir capture", d[3:0], `BST_IR_CAPTURE);
  endtask : ir_load

  task t_idcode;
    tester.tap_reset();
    tester.scan(1'b0, 32, 64'h0, 9, d, ok);
    check("id value", d[31:0], `BST_ID_CODE);
    check("shift enable and freeze", ok, 1'b1);
  endtask : t_idcode

  task t_test_reset;
    logic q;
    tester.step(1'b1, 1'b0, q);
    tester.step(1'b0, 1'b0, q);
    tester.step(1'b0, 1'b0, q);
    check("oe in shift", tdo_oe, 1'b1);
    tester.trst_n_o = 1'b0;
    #5;
    check("oe after async reset", tdo_oe, 1'b0);
    tester.tap_reset();
  endtask : t_test_reset

  task t_bypass;
    logic [3:0] codes [2];
    codes = '{`BST_IR_BYPASS, 4'h6};
    foreach (codes[k]) begin
      ir_load(codes[k]);
      tester.scan(1'b0, 9, 64'h0d3, -1, d, ok);
      check("bypass path", d[8:0], 9'h1a6);
    end
  endtask : t_bypass

  task t_sample;
    sys_hold = 1'b0;
    @(posedge clock_i);
    #1;
    pin_in = 8'ha5;
    core_out = 8'h5a;
    settle();
    ir_load(`BST_IR_SAMPLE);
    tester.scan(1'b0, 17, 64'h13c00, -1, d, ok);
    check("sampled pins", d[15:0], 16'h5aa5);
    settle();
    check("pads under preload", pad_out, 8'h5a);
    check("pad enable under preload", pad_oe, 1'b1);
    check("core inputs under sample", core_in, 8'ha5);
  endtask : t_sample

  task t_extest;
    // Pins are asynchronous, so no system clock edge is needed here
    pin_in = 8'h96;
    ir_load(`BST_IR_EXTEST);
    settle();
    check("preloaded pads", pad_out, 8'h3c);
    tester.scan(1'b0, 17, 64'h0c300, -1, d, ok);
    check("captured pins", d[7:0], 8'h96);
    settle();
    check("extest pads", pad_out, 8'hc3);
    check("extest disable", pad_oe, 1'b0);
  endtask : t_extest

  task t_intest;
    ir_load(`BST_IR_INTEST);
    tester.scan(1'b0, 17, 64'h10069, -1, d, ok);
    settle();
    check("intest core inputs", core_in, 8'h69);
  endtask : t_intest

  task t_parity;
    ir_load(`BST_IR_PARSCAN);
    tester.scan(1'b0, 4, 64'hb, -1, d, ok);
    settle();
    check("parity force", par_force, 4'hb);
    // Refills the chain with 0xb, so the release below is due to the instruction
    tester.scan(1'b0, 5, 64'h16, -1, d, ok);
    check("parity chain length", d[4:0], 5'h0b);
    ir_load(`BST_IR_BYPASS);
    settle();
    check("parity force released", par_force, 4'h0);
  endtask : t_parity

  initial begin
    clock_i = 1'b0;
    sys_hold = 1'b0;
    rst_i = 1'b1;
    pin_in = 8'h00;
    core_out = 8'h00;
    core_oe = 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    sys_hold = 1'b1;
    t_idcode();
    t_test_reset();
    t_bypass();
    t_sample();
    t_extest();
    t_intest();
    t_parity();
    stop_test();
  end

  // Whole sequence needs well under 40 us
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule : boundary_scan_test_port_tb

// [testbench/bst_tester.sv]
`timescale 1ns/10ps

module bst_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // Clock parked low between frames; reset held until the bench calls tap_reset
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end

  // One test clock cycle of 30 ns, inputs moved only while the clock is low
  // Ends 1 ns after the falling edge, so callers see settled outputs
  task step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #14;
    tck_o = 1'b1;
    q = tdo_i;
    #15;
    tck_o = 1'b0;
    #1;
  endtask : step

  task tap_reset;
    logic q;
    trst_n_o = 1'b0;
    #20;
    // A clock pulse in reset starts the sampled history from reset values
    step(1'b1, 1'b0, q);
    trst_n_o = 1'b1;
    step(1'b0, 1'b0, q);
  endtask : tap_reset

  // From idle through capture, n shift bits, update and back to idle
  task scan(input logic ir, input int n, input logic [63:0] din, input int stop,
            output logic [63:0] dout, output logic ok);
    logic q;
    logic q0;
    int   i;
    dout = '0;
    ok = 1'b1;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (i = 0; i < n; i++) begin
      if (i == stop) begin
        // Long stop with the clock low must leave the shift untouched
        q0 = tdo_i;
        #3000;
        ok &= (tdo_i === q0);
      end
      ok &= (tdo_oe_i === 1'b1);
      step(logic'(i == n - 1), din[i], q);
      dout[i] = q;
    end
    ok &= (tdo_oe_i === 1'b0);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : bst_tester
